// file: hdl/ddw_pkg.sv
// Purpose: Shared constants for the dual converter trigger/wave control
// Assumes: 32-bit Avalon-MM register slave, byte addresses
// Notes: Field positions given for channel 0; channel 1 adds CH_STRIDE
package ddw_pkg;
  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_CONTROL = 8'h00;
  localparam logic [7:0] OFF_SOFT_TRIG = 8'h04;
  localparam logic [7:0] OFF_CH0_HOLD = 8'h08;
  localparam logic [7:0] OFF_CH1_HOLD = 8'h14;
  localparam logic [7:0] OFF_CH0_OUT = 8'h2c;
  localparam logic [7:0] OFF_CH1_OUT = 8'h30;
  // ==========================================================
  // Control field positions for channel 0
  localparam int CH_STRIDE = 16;
  localparam int POS_ON = 0;
  localparam int POS_BUF_OFF = 1;
  localparam int POS_TRIG_ON = 2;
  localparam int POS_TRIG_SRC = 3;
  localparam int POS_WAVE_MODE = 6;
  localparam int POS_WAVE_WIDTH = 8;
  localparam int POS_DMA_ON = 12;
  // Writable bits of the control word
  localparam logic [31:0] CONTROL_MASK = 32'h1fff_1fff;
  // ==========================================================
  // Reset values
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [1:0] SOFT_TRIG_RESET = 2'h0;
  localparam logic [11:0] HOLD_RESET = 12'h000;
  localparam logic [11:0] LFSR_SEED = 12'haaa;
  // ==========================================================
  // Codes
  localparam logic [2:0] SRC_LAST_TIMER = 3'h5;
  localparam logic [2:0] SRC_EXT_LINE = 3'h6;
  localparam logic [2:0] SRC_SOFT = 3'h7;
  localparam logic [1:0] WAVE_NONE = 2'h0;
  localparam logic [1:0] WAVE_LFSR = 2'h1;
  localparam logic [3:0] WIDTH_MAX_CODE = 4'hb;
  localparam logic [11:0] FULL_MASK = 12'hfff;

  // Low-bit mask of width code plus one, saturating at 12 bits
  function automatic logic [11:0] wave_mask(input logic [3:0] code);
    logic [3:0] c;
    c = (code >= WIDTH_MAX_CODE) ? WIDTH_MAX_CODE : code;
    wave_mask = FULL_MASK >> (4'hb - c);
  endfunction

  // True for a hardware trigger source code
  function automatic logic src_is_hw(input logic [2:0] src);
    src_is_hw = (src != SRC_SOFT);
  endfunction
endpackage

// file: hdl/ddw_wave_gen.sv
// Purpose: Noise or triangle value for one converter channel
// Assumes: i_step is a one-cycle pulse per accepted trigger
// Notes: Output is zero while the mode selects no wave
`timescale 1ns/1ps
`default_nettype none
module ddw_wave_gen
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Control
  input wire logic i_step,
  input wire logic [1:0] i_mode,
  input wire logic [3:0] i_width,
  // Result
  output logic [11:0] o_wave
);
  // ==========================================================
  // Generator state
  logic [11:0] lfsr_q;
  logic [11:0] tri_q;
  logic up_q;
  logic [11:0] mask;
  logic fb;

  assign mask = ddw_pkg::wave_mask(i_width);
  assign fb = lfsr_q[11] ^ lfsr_q[5] ^ lfsr_q[3] ^ lfsr_q[0];

  // LFSR advances on each step in noise mode
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      lfsr_q <= ddw_pkg::LFSR_SEED;
    else if (i_step && i_mode == ddw_pkg::WAVE_LFSR)
      lfsr_q <= {lfsr_q[10:0], fb};
  end

  // triangle climbs from zero to amplitude and back
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      tri_q <= 12'h000;
      up_q <= 1'b1;
    end
    else if (i_step && i_mode[1])
    begin
      if (tri_q >= mask)
      begin
        up_q <= 1'b0;
        tri_q <= mask - 12'h001;
      end
      else if (up_q)
        tri_q <= tri_q + 12'h001;
      else if (tri_q == 12'h000)
      begin
        up_q <= 1'b1;
        tri_q <= 12'h001;
      end
      else
        tri_q <= tri_q - 12'h001;
    end
  end

  // mode decode, upper bit selects triangle
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_wave <= 12'h000;
    else if (i_mode[1])
      o_wave <= tri_q;
    else if (i_mode == ddw_pkg::WAVE_LFSR)
      o_wave <= lfsr_q & mask; // unmasks low bits
    else
      o_wave <= 12'h000;
  end

  // ==========================================================
  // Checks
  a_no_wave_zero: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_mode == ddw_pkg::WAVE_NONE |=> o_wave == 12'h000)
    else $error("wave not zero with no wave mode");
  a_lfsr_masked: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_mode == ddw_pkg::WAVE_LFSR |=> (o_wave & ~$past(mask)) == 12'h000)
    else $error("noise bits above width");
endmodule
`default_nettype wire

// file: hdl/ddw_ctrl.sv
// Function
// - Wave mode 00 none, 01 noise, 1x triangle
// - Source 0-5 timers, 6 line, 7 software
// - Bit 18 trigger enable ch1, select 21:19
// - Bit 17 turns ch1 output buffer off
// - Bits 0 and 16 enable the channels
// - Bits 12 and 28 enable channel DMA
// - Width code plus one, saturating at twelve
// - Ch0 fields at 7:6, 5:3, 2, 1
// - Software trigger bits at 0x04, self-clearing
// - Ch0 data 11:0 at 0x08, words only
// - Copy holding data on trigger or automatically
// - DMA request only on hardware trigger
// - Add wave to holding data, triangle from zero
//
// Purpose: Register slave and trigger/transfer logic of a two-channel DAC
// Assumes: Trigger inputs synchronous to i_clk, rising edge is an event
// Notes: Every access takes two cycles; waitrequest idles high
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ddw_ctrl
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Avalon-MM slave
  input wire logic [7:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Trigger sources
  input wire logic [5:0] i_timer_trigger_out,
  input wire logic i_external_interrupt_line,
  // Channel controls
  output logic o_ch0_on,
  output logic o_ch1_on,
  output logic o_ch0_buffer_off,
  output logic o_ch1_buffer_off,
  // Converter data
  output logic [11:0] o_ch0_output_value,
  output logic [11:0] o_ch1_output_value,
  // DMA requests
  output logic o_ch0_dma_req,
  output logic o_ch1_dma_req
);
  // ==========================================================
  // Bus handshake
  logic wait_q;
  logic req;
  logic acc_wr;
  logic acc_rd_start;
  logic full_word;

  assign req = i_avs_read || i_avs_write;
  assign acc_wr = i_avs_write && !wait_q;
  assign acc_rd_start = i_avs_read && wait_q;
  assign full_word = (i_avs_byteenable == 4'hf);

  // Waitrequest drops for one cycle per request
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      wait_q <= 1'b1;
    else
      wait_q <= !(wait_q && req);
  end
  assign o_avs_waitrequest = wait_q;

  // ==========================================================
  // Registers
  logic [31:0] ctl_q;
  logic [1:0] swt_q;
  logic [11:0] hold_q [2];
  logic [11:0] out_q [2];

  // Control word with per-lane writes, reserved bits kept zero
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      ctl_q <= ddw_pkg::CONTROL_RESET;
    else if (acc_wr && i_avs_address == ddw_pkg::OFF_CONTROL)
    begin
      for (int b = 0; b < 4; b++)
      begin
        if (i_avs_byteenable[b])
          ctl_q[8*b +: 8] <= i_avs_writedata[8*b +: 8]
                             & ddw_pkg::CONTROL_MASK[8*b +: 8];
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      swt_q <= ddw_pkg::SOFT_TRIG_RESET;
    else if (acc_wr && i_avs_address == ddw_pkg::OFF_SOFT_TRIG
             && i_avs_byteenable[0])
      swt_q <= i_avs_writedata[1:0];
    else
      swt_q <= 2'h0; // gone the cycle after use
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      hold_q[0] <= ddw_pkg::HOLD_RESET;
      hold_q[1] <= ddw_pkg::HOLD_RESET;
    end
    else if (acc_wr && full_word)
    begin
      if (i_avs_address == ddw_pkg::OFF_CH0_HOLD)
        hold_q[0] <= i_avs_writedata[11:0];
      else if (i_avs_address == ddw_pkg::OFF_CH1_HOLD)
        hold_q[1] <= i_avs_writedata[11:0];
    end
  end

  // Read data latched at the first edge, zero if unmapped
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_avs_readdata <= 32'h0000_0000;
    else if (acc_rd_start)
    begin
      if (i_avs_address == ddw_pkg::OFF_CONTROL)
        o_avs_readdata <= ctl_q;
      else if (i_avs_address == ddw_pkg::OFF_CH0_HOLD)
        o_avs_readdata <= {20'h00000, hold_q[0]};
      else if (i_avs_address == ddw_pkg::OFF_CH1_HOLD)
        o_avs_readdata <= {20'h00000, hold_q[1]};
      else if (i_avs_address == ddw_pkg::OFF_CH0_OUT)
        o_avs_readdata <= {20'h00000, out_q[0]};
      else if (i_avs_address == ddw_pkg::OFF_CH1_OUT)
        o_avs_readdata <= {20'h00000, out_q[1]};
      else
        o_avs_readdata <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // Trigger edge detection
  logic [5:0] tmr_prev_q;
  logic ext_prev_q;
  logic [5:0] tmr_rise;
  logic ext_rise;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      tmr_prev_q <= 6'h00;
      ext_prev_q <= 1'b0;
    end
    else
    begin
      tmr_prev_q <= i_timer_trigger_out;
      ext_prev_q <= i_external_interrupt_line;
    end
  end
  assign tmr_rise = i_timer_trigger_out & ~tmr_prev_q;
  assign ext_rise = i_external_interrupt_line && !ext_prev_q;

  // ==========================================================
  // Per-channel fields, events and transfer
  logic [1:0] ch_on;
  logic [1:0] buf_off;
  logic [1:0] trig_on;
  logic [1:0] dma_on;
  logic [2:0] src [2];
  logic [1:0] mode [2];
  logic [3:0] width [2];
  logic [1:0] hw_evt;
  logic [1:0] evt;
  logic [11:0] wave [2];
  logic [1:0] ch_on_q;
  logic [1:0] buf_off_q;
  logic [1:0] dma_q;

  for (genvar c = 0; c < 2; c++)
  begin : g_ch
    localparam int B = c * ddw_pkg::CH_STRIDE;
    // field placement, channel 1 copy at 16 up
    assign ch_on[c] = ctl_q[B + ddw_pkg::POS_ON];
    assign buf_off[c] = ctl_q[B + ddw_pkg::POS_BUF_OFF];
    assign trig_on[c] = ctl_q[B + ddw_pkg::POS_TRIG_ON];
    assign src[c] = ctl_q[B + ddw_pkg::POS_TRIG_SRC +: 3];
    assign mode[c] = trig_on[c] ? ctl_q[B + ddw_pkg::POS_WAVE_MODE +: 2]
                                : ddw_pkg::WAVE_NONE;
    assign width[c] = ctl_q[B + ddw_pkg::POS_WAVE_WIDTH +: 4];
    assign dma_on[c] = ctl_q[B + ddw_pkg::POS_DMA_ON];

    // source select used only with trigger on
    always_comb
    begin
      if (src[c] <= ddw_pkg::SRC_LAST_TIMER)
        hw_evt[c] = tmr_rise[src[c]];
      else if (src[c] == ddw_pkg::SRC_EXT_LINE)
        hw_evt[c] = ext_rise;
      else
        hw_evt[c] = 1'b0;
    end
    assign evt[c] = ch_on[c] && trig_on[c]
                    && (hw_evt[c] || (src[c] == ddw_pkg::SRC_SOFT
                                      && swt_q[c]));

    ddw_wave_gen u_wave
    (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_step(evt[c]),
      .i_mode(mode[c]),
      .i_width(width[c]),
      .o_wave(wave[c])
    );

    // copy on event, or every cycle while the channel is on without trigger
    always_ff @(posedge i_clk)
    begin
      if (i_sys_rst)
        out_q[c] <= ddw_pkg::HOLD_RESET;
      else if (ch_on[c] && !trig_on[c])
        out_q[c] <= hold_q[c];
      else if (evt[c])
        out_q[c] <= hold_q[c] + wave[c]; // sum wraps at 12 bits
    end

    // DMA pulse on hardware events only
    always_ff @(posedge i_clk)
    begin
      if (i_sys_rst)
        dma_q[c] <= 1'b0;
      else
        dma_q[c] <= evt[c] && dma_on[c] && ddw_pkg::src_is_hw(src[c]);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      ch_on_q <= 2'h0;
      buf_off_q <= 2'h0;
    end
    else
    begin
      ch_on_q <= ch_on;
      buf_off_q <= buf_off;
    end
  end

  assign o_ch0_on = ch_on_q[0];
  assign o_ch1_on = ch_on_q[1];
  assign o_ch0_buffer_off = buf_off_q[0];
  assign o_ch1_buffer_off = buf_off_q[1];
  assign o_ch0_output_value = out_q[0];
  assign o_ch1_output_value = out_q[1];
  assign o_ch0_dma_req = dma_q[0];
  assign o_ch1_dma_req = dma_q[1];

  // ==========================================================
  // Checks
  a_wait_answer: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    req && wait_q |=> !wait_q ##1 wait_q)
    else $error("waitrequest not low for exactly one cycle");

  a_swt_one_shot: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    swt_q[1] |=> !swt_q[1])
    else $error("software trigger held more than one cycle");

  a_swt_set: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    acc_wr && i_avs_address == ddw_pkg::OFF_SOFT_TRIG && full_word
    |=> swt_q == $past(i_avs_writedata[1:0]))
    else $error("software trigger write not captured");

  a_hold_word: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    acc_wr && !full_word |=> $stable(hold_q[0]))
    else $error("partial write changed holding data");

  a_auto_copy: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ctl_q[0] && !ctl_q[2] |=> out_q[0] == $past(hold_q[0]))
    else $error("automatic transfer missing");

  a_trig_wait: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ctl_q[18] && !evt[1] |=> $stable(out_q[1]))
    else $error("triggered channel changed without event");

  a_dma_hw_only: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_ch0_dma_req |-> $past(ctl_q[12] && ctl_q[2]
                            && ctl_q[5:3] != ddw_pkg::SRC_SOFT))
    else $error("dma request without hardware trigger");

  a_dma_enable: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    evt[1] && !ctl_q[28] |=> !o_ch1_dma_req)
    else $error("dma request while dma disabled");

  a_buffer_off: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(ctl_q[17]) |=> o_ch1_buffer_off ##1 o_ch1_buffer_off
    || !ctl_q[17])
    else $error("buffer-off not following control bit");

  a_ch_enable: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !ctl_q[16] |=> !o_ch1_on)
    else $error("channel on while enable bit clear");

  a_soft_event: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ctl_q[0] && ctl_q[2] && ctl_q[5:3] == ddw_pkg::SRC_SOFT && swt_q[0]
    |-> evt[0])
    else $error("software trigger not taken");

  a_swt_ch0_shot: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    swt_q[0] |=> !swt_q[0])
    else $error("channel 0 software trigger held too long");

  a_ch0_enable: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    !ctl_q[0] |=> !o_ch0_on)
    else $error("channel 0 on while enable bit clear");

  a_dma_ch1_hw: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    o_ch1_dma_req |-> $past(ctl_q[28] && ctl_q[18]
                            && ctl_q[21:19] != ddw_pkg::SRC_SOFT))
    else $error("channel 1 dma request without hardware trigger");

  a_buf0_follow: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    ctl_q[1] |=> o_ch0_buffer_off)
    else $error("channel 0 buffer-off not following control bit");

  a_ch1_auto_copy: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    ctl_q[16] && !ctl_q[18] |=> out_q[1] == $past(hold_q[1]))
    else $error("channel 1 automatic transfer missing");

  a_ext_event: assert property (
    @(posedge i_clk) disable iff (i_sys_rst)
    ctl_q[16] && ctl_q[18] && ctl_q[21:19] == ddw_pkg::SRC_EXT_LINE
    && ext_rise |-> evt[1])
    else $error("external line trigger not taken");
endmodule
`default_nettype wire

// file: tb/ddw_ctrl_tb_top.sv
// Purpose: Self-checking bench for the converter trigger and wave control
// Assumes: Avalon-MM slave answers one cycle after it sees a request
// Notes: Each scenario is its own task and judges its own results
`timescale 1ns/1ps
`default_nettype none
module ddw_ctrl_tb_top;
  // ==========================================================
  // Signals
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [3:0] be = 4'hf;
  logic [31:0] rdat;
  logic wreq;
  logic [5:0] tmr = 6'h00;
  logic ext = 1'b0;
  logic on0, on1, bo0, bo1, dq0, dq1;
  logic [11:0] out0, out1;
  int err_total = 0;
  int samples_checked = 0;
  int dn0 = 0;
  int dn1 = 0;
  logic [31:0] r;

  // Compare two values
  `define CHK(g, e) check_val(32'(g), 32'(e))

  // Clock at 250 MHz
  always #2 i_clk = ~i_clk;

  // Count DMA pulses per channel
  always @(posedge i_clk)
  begin
    if (dq0 === 1'b1) dn0 <= dn0 + 1;
    if (dq1 === 1'b1) dn1 <= dn1 + 1;
  end

  ddw_ctrl i_ddw_ctrl (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wreq), .i_timer_trigger_out(tmr),
    .i_external_interrupt_line(ext), .o_ch0_on(on0), .o_ch1_on(on1),
    .o_ch0_buffer_off(bo0), .o_ch1_buffer_off(bo1),
    .o_ch0_output_value(out0), .o_ch1_output_value(out1),
    .o_ch0_dma_req(dq0), .o_ch1_dma_req(dq1));

  // ==========================================================
  // Helpers
  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic finish_test();
    $display("Checked %0d values, %0d mismatches", samples_checked,
      err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // One bus access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [3:0] b);
    int n;
    @(posedge i_clk);
    adr <= a;
    wd <= d;
    be <= b;
    wr <= w;
    rd <= ~w;
    n = 0;
    do
    begin
      @(posedge i_clk);
      n++;
    end
    while (wreq !== 1'b0 && n < 20);
    r = rdat;
    if (n >= 20)
    begin
      err_total++;
      finish_test();
    end
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  // One rising edge on a timer (0..5) or the external line (6)
  task automatic pulse(input int k);
    @(posedge i_clk);
    if (k == 6) ext <= 1'b1;
    else tmr[k] <= 1'b1;
    @(posedge i_clk);
    ext <= 1'b0;
    tmr <= 6'h00;
    repeat (3) @(posedge i_clk);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    bus(0, 8'h00, 0, 4'hf); `CHK(r, 32'h0);
    bus(0, 8'h08, 0, 4'hf); `CHK(r, 32'h0);
    bus(0, 8'h04, 0, 4'hf); `CHK(r, 32'h0);
    bus(0, 8'h40, 0, 4'hf); `CHK(r, 32'h0);
    `CHK({on0, on1, bo0, bo1, out0}, 16'h0);
    $display("Test reset done");
  endtask

  task automatic t_control();
    bus(1, 8'h00, 32'hffff_ffff, 4'hf);
    bus(0, 8'h00, 0, 4'hf); `CHK(r, 32'h1fff_1fff);
    `CHK({on0, on1, bo0, bo1}, 4'hf);
    bus(1, 8'h00, 32'h0002_0001, 4'hf);
    repeat (2) @(posedge i_clk);
    `CHK({on0, on1, bo0, bo1}, 4'b1001);
    bus(1, 8'h00, 32'h0001_0002, 4'hf);
    repeat (2) @(posedge i_clk);
    `CHK({on0, on1, bo0, bo1}, 4'b0110);
    $display("Test control done");
  endtask

  task automatic t_auto();
    bus(1, 8'h00, 32'h0001_0001, 4'hf);
    bus(1, 8'h08, 32'h0000_0123, 4'hf);
    bus(1, 8'h14, 32'h0000_0456, 4'hf);
    repeat (3) @(posedge i_clk);
    `CHK({out0, out1}, 24'h123456);
    bus(0, 8'h08, 0, 4'hf); `CHK(r, 32'h123);
    bus(1, 8'h08, 32'h0000_0055, 4'h1);
    repeat (3) @(posedge i_clk);
    `CHK(out0, 12'h123);
    `CHK(dn0 + dn1, 0);
    $display("Test auto copy done");
  endtask

  task automatic t_hw_trig();
    int c0, c1;
    logic [11:0] p0, p1;
    for (int k = 0; k < 7; k++)
    begin
      c0 = dn0;
      c1 = dn1;
      p0 = out0;
      p1 = out1;
      bus(1, 8'h00, 32'h1005_1005 | (k << 3) | (k << 19), 4'hf);
      bus(1, 8'h08, 32'h100 + k, 4'hf);
      bus(1, 8'h14, 32'h200 + k, 4'hf);
      pulse((k + 1) % 7);
      `CHK({out0, out1}, {p0, p1});
      pulse(k);
      `CHK(out0, 12'h100 + k);
      `CHK(out1, 12'h200 + k);
      `CHK(dn0 - c0, 1);
      `CHK(dn1 - c1, 1);
    end
    $display("Test hardware triggers done");
  endtask

  task automatic t_soft();
    int c;
    c = dn0 + dn1;
    bus(1, 8'h00, 32'h103d_103d, 4'hf);
    bus(1, 8'h08, 32'h321, 4'hf);
    bus(1, 8'h14, 32'h654, 4'hf);
    bus(1, 8'h04, 32'h1, 4'hf);
    repeat (2) @(posedge i_clk);
    `CHK(out0, 12'h321);
    `CHK(out1, 12'h206);
    bus(0, 8'h04, 0, 4'hf); `CHK(r, 32'h0);
    bus(1, 8'h08, 32'h322, 4'hf);
    repeat (3) @(posedge i_clk);
    `CHK(out0, 12'h321);
    bus(1, 8'h04, 32'h2, 4'hf);
    repeat (2) @(posedge i_clk);
    `CHK(out1, 12'h654);
    `CHK(dn0 + dn1, c);
    $display("Test software trigger done");
  endtask

  task automatic t_wave();
    logic [11:0] tri_seq [6] = '{0, 1, 2, 3, 2, 1};
    bus(1, 8'h00, 32'h0185_034d, 4'hf);
    bus(1, 8'h08, 32'h010, 4'hf);
    bus(1, 8'h14, 32'h020, 4'hf);
    repeat (3) @(posedge i_clk);
    for (int i = 0; i < 6; i++)
    begin
      pulse(0);
      `CHK(out1, 12'h020 + tri_seq[i]);
    end
    pulse(1);
    `CHK(out0, 12'h010 + (ddw_pkg::LFSR_SEED & 12'h00f));
    bus(1, 8'h00, 32'h0, 4'hf);
    repeat (2) @(posedge i_clk);
    `CHK({on0, on1}, 2'b00);
    $display("Test wave done");
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (8) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    t_reset();
    t_control();
    t_auto();
    t_hw_trig();
    t_soft();
    t_wave();
    finish_test();
  end
endmodule
`default_nettype wire
